//--- core/sep_pkg.sv
// shared constants, types and size functions for the serial eeprom command block
package sep_pkg;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int unsigned SEP_CLK_MHZ           = 100;
  localparam int unsigned SEP_WORD_PROG_TIME_US = 10000;
  localparam int unsigned SEP_ERASE_ALL_TIME_US = 20000;
  localparam int unsigned SEP_WRITE_ALL_TIME_US = 40000;
  localparam int unsigned SEP_WORD_PROG_CYC     = SEP_WORD_PROG_TIME_US * SEP_CLK_MHZ;
  localparam int unsigned SEP_ERASE_ALL_CYC     = SEP_ERASE_ALL_TIME_US * SEP_CLK_MHZ;
  localparam int unsigned SEP_WRITE_ALL_CYC     = SEP_WRITE_ALL_TIME_US * SEP_CLK_MHZ;
  localparam int unsigned SEP_TIMER_W           = 23;

  // -----------------------------------------------------------------
  // geometry and reset values
  // -----------------------------------------------------------------
  localparam int unsigned SEP_MEM_BYTES = 512;
  localparam int unsigned SEP_OPC_BITS  = 2;
  localparam logic [1:0]  SEP_PART_1K   = 2'h0;
  localparam logic [1:0]  SEP_PART_2K   = 2'h1;
  localparam logic [1:0]  SEP_PART_4K   = 2'h2;
  localparam logic [15:0] SEP_ERASED    = 16'hffff;
  localparam logic        SEP_EN_RST    = 1'b0;

  typedef enum logic [1:0] {
    SEP_OP_SPECIAL = 2'b00,
    SEP_OP_WRITE   = 2'b01,
    SEP_OP_READ    = 2'b10,
    SEP_OP_ERASE   = 2'b11
  } sep_op_type;

  typedef enum logic [1:0] {
    SEP_SUB_DISABLE   = 2'b00,
    SEP_SUB_WRITE_ALL = 2'b01,
    SEP_SUB_ERASE_ALL = 2'b10,
    SEP_SUB_ENABLE    = 2'b11
  } sep_sub_type;

  typedef enum logic [2:0] {
    SEP_ST_IDLE = 3'b000,
    SEP_ST_HDR  = 3'b001,
    SEP_ST_DATA = 3'b010,
    SEP_ST_READ = 3'b011,
    SEP_ST_DONE = 3'b100
  } sep_state_type;

  // received address length per part and width
  function automatic logic [3:0] sep_addr_bits(input logic [1:0] part, input logic wide);
    if (part == SEP_PART_1K) begin
      return wide ? 4'h6 : 4'h7;
    end
    return wide ? 4'h8 : 4'h9;
  endfunction : sep_addr_bits

  // significant address bits; the middle part ignores the top received bit
  function automatic logic [3:0] sep_sig_bits(input logic [1:0] part, input logic wide);
    if (part == SEP_PART_1K) begin
      return wide ? 4'h6 : 4'h7;
    end
    if (part == SEP_PART_2K) begin
      return wide ? 4'h7 : 4'h8;
    end
    return wide ? 4'h8 : 4'h9;
  endfunction : sep_sig_bits

endpackage : sep_pkg

//--- core/sep_eeprom.sv
// three-wire serial eeprom device core: command decode, array and programming timer
`timescale 1ns/1ps
`default_nettype none

module sep_eeprom
  import sep_pkg::*;
#(
  parameter logic [1:0]  PART_SEL       = SEP_PART_4K,
  parameter int unsigned WORD_PROG_CYC  = SEP_WORD_PROG_CYC,
  parameter int unsigned ERASE_ALL_CYC  = SEP_ERASE_ALL_CYC,
  parameter int unsigned WRITE_ALL_CYC  = SEP_WRITE_ALL_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic cs_i,
  input  wire logic sclk_i,
  input  wire logic serial_in_i,
  input  wire logic width_select_i,
  output logic      serial_out_o,
  output logic      serial_out_oe_o,
  output logic      standby_o
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  // pin syncs, command decode, read shifter and programming timer share one
  // record; the _m fields are first sync stages and feed only their _s
  // partners
  typedef struct packed {
    logic                   cs_m;
    logic                   cs_s;
    logic                   cs_d;
    logic                   ck_m;
    logic                   ck_s;
    logic                   ck_d;
    logic                   di_m;
    logic                   di_s;
    logic                   ws_m;
    logic                   ws_s;
    sep_state_type          state;
    logic [4:0]             cnt;
    logic [10:0]            hdr;
    logic                   wide;
    logic [8:0]             idx;
    logic [15:0]            dat;
    logic [15:0]            rsh;
    logic                   pend;
    logic [1:0]             kind;
    logic                   busy;
    logic [SEP_TIMER_W-1:0] timer;
    logic                   en;
    logic                   stat;
    logic                   so;
    logic                   oe;
  } sep_regs_type;

  localparam sep_regs_type SEP_REGS_RST = '{
    state: SEP_ST_IDLE,
    kind:  SEP_OP_SPECIAL,
    en:    SEP_EN_RST,
    default: '0
  };

  sep_regs_type st_ff;
  sep_regs_type nxt_st;

  // byte array; a 16-bit word sits at an even/odd byte pair, low byte even
  logic [7:0] mem_ff [SEP_MEM_BYTES];

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // fetch a word left aligned so the msb always leaves first
  function automatic logic [15:0] rd_word(input logic [8:0] i, input logic wide);
    if (wide) begin
      return {mem_ff[{i[7:0], 1'b1}], mem_ff[{i[7:0], 1'b0}]};
    end
    return {mem_ff[i], 8'h00};
  endfunction : rd_word

  function automatic logic [8:0] sig_mask(input logic wide);
    return 9'((10'h001 << sep_sig_bits(PART_SEL, wide)) - 10'h001);
  endfunction : sig_mask

  logic       ck_rise;
  logic       cs_fall;
  logic [3:0] abits;
  logic [4:0] hlen;
  logic [4:0] dlen;
  logic [10:0] hdr_n;
  logic [1:0] op_n;
  logic [1:0] sub_n;
  logic [8:0] idx_n;
  logic [8:0] idx_inc;
  logic [15:0] word_n;
  logic       prog_done;

  // edges come from the second sync stage and its delayed copy only; the first
  // stage may still be settling and must feed nothing but the second stage
  // a rise shows two to three system clocks after the pin moves, so the
  // serial clock has to stay high and low for several system clocks each
  // di_s has the same sync depth as ck_s, so the bit taken is the one that
  // stood when the synced rise appeared, well clear of the master's changes
  assign ck_rise   = st_ff.ck_s & ~st_ff.ck_d;
  assign cs_fall   = st_ff.cs_d & ~st_ff.cs_s;
  assign abits     = sep_addr_bits(PART_SEL, st_ff.ws_s);
  assign hlen      = 5'(SEP_OPC_BITS) + {1'b0, abits};
  assign dlen      = st_ff.wide ? 5'h10 : 5'h08;
  assign hdr_n     = {st_ff.hdr[9:0], st_ff.di_s};
  assign op_n      = 2'(hdr_n >> abits);
  assign sub_n     = 2'(hdr_n >> (abits - 4'h2));
  assign idx_n     = 9'(hdr_n) & sig_mask(st_ff.ws_s);
  assign idx_inc   = (st_ff.idx + 9'h001) & sig_mask(st_ff.wide);
  assign word_n    = rd_word((st_ff.state == SEP_ST_HDR) ? idx_n : idx_inc,
                             (st_ff.state == SEP_ST_HDR) ? st_ff.ws_s : st_ff.wide);
  assign prog_done = st_ff.busy && (st_ff.timer == SEP_TIMER_W'(1));

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // two flops on every pin input; ck_d delays the synced clock by one
    nxt_st.cs_m = cs_i;
    nxt_st.cs_s = st_ff.cs_m;
    nxt_st.cs_d = st_ff.cs_s;
    nxt_st.ck_m = sclk_i;
    nxt_st.ck_s = st_ff.ck_m;
    nxt_st.ck_d = st_ff.ck_s;
    nxt_st.di_m = serial_in_i;
    nxt_st.di_s = st_ff.di_m;
    nxt_st.ws_m = width_select_i;
    nxt_st.ws_s = st_ff.ws_m;

    // self-timed cycle runs on regardless of chip select
    // the timer is the only way out of busy; new starts are refused meanwhile,
    // so a master that never polls still gets a finished cycle
    if (st_ff.busy) begin
      nxt_st.timer = st_ff.timer - SEP_TIMER_W'(1);
      if (prog_done) begin
        nxt_st.busy = 1'b0;
      end
    end

    if (!st_ff.cs_s) begin
      // select low: control logic held in reset, output floated
      nxt_st.state = SEP_ST_IDLE;
      nxt_st.cnt   = '0;
      nxt_st.pend  = 1'b0;
      nxt_st.oe    = 1'b0;
      if (cs_fall && st_ff.pend && !st_ff.busy) begin
        // falling select after a complete command fires programming
        nxt_st.busy = 1'b1;
        nxt_st.stat = 1'b1;
        unique case (st_ff.kind)
          SEP_OP_WRITE,
          SEP_OP_ERASE: nxt_st.timer = SEP_TIMER_W'(WORD_PROG_CYC);
          SEP_OP_READ:  nxt_st.timer = SEP_TIMER_W'(ERASE_ALL_CYC);
          SEP_OP_SPECIAL: nxt_st.timer = SEP_TIMER_W'(WRITE_ALL_CYC);
        endcase
      end else if (cs_fall && !st_ff.busy) begin
        nxt_st.stat = 1'b0;  // ready already seen; status no longer owed
      end
    end else begin
      unique case (st_ff.state)
        SEP_ST_IDLE: begin
          // busy parts ignore new starts so the pending status is not lost
          if (ck_rise && st_ff.di_s && !st_ff.busy) begin
            nxt_st.state = SEP_ST_HDR;
            nxt_st.cnt   = '0;
            nxt_st.hdr   = '0;
            nxt_st.stat  = 1'b0;
          end
        end
        SEP_ST_HDR: begin
          if (ck_rise) begin
            nxt_st.hdr = hdr_n;
            nxt_st.cnt = st_ff.cnt + 5'h01;
            if (st_ff.cnt + 5'h01 == hlen) begin
              nxt_st.wide  = st_ff.ws_s;
              nxt_st.idx   = idx_n;
              nxt_st.cnt   = '0;
              nxt_st.state = SEP_ST_DONE;
              unique case (op_n)
                SEP_OP_READ: begin
                  nxt_st.state = SEP_ST_READ;
                  nxt_st.rsh   = word_n;
                  nxt_st.so    = 1'b0;
                  nxt_st.oe    = 1'b1;
                end
                SEP_OP_WRITE: begin
                  nxt_st.state = SEP_ST_DATA;
                  nxt_st.kind  = SEP_OP_WRITE;
                end
                SEP_OP_ERASE: begin
                  nxt_st.pend = st_ff.en;
                  nxt_st.kind = SEP_OP_ERASE;
                end
                SEP_OP_SPECIAL: begin
                  unique case (sub_n)
                    SEP_SUB_ENABLE:  nxt_st.en = 1'b1;
                    SEP_SUB_DISABLE: nxt_st.en = 1'b0;
                    SEP_SUB_ERASE_ALL: begin
                      nxt_st.pend = st_ff.en;
                      nxt_st.kind = SEP_OP_READ;  // kind code reused for erase all
                    end
                    SEP_SUB_WRITE_ALL: begin
                      nxt_st.state = SEP_ST_DATA;
                      nxt_st.kind  = SEP_OP_SPECIAL;  // kind code for write all
                    end
                  endcase
                end
              endcase
            end
          end
        end
        SEP_ST_DATA: begin
          if (ck_rise) begin
            nxt_st.dat = {st_ff.dat[14:0], st_ff.di_s};
            nxt_st.cnt = st_ff.cnt + 5'h01;
            if (st_ff.cnt + 5'h01 == dlen) begin
              nxt_st.pend  = st_ff.en;
              nxt_st.state = SEP_ST_DONE;
            end
          end
        end
        SEP_ST_READ: begin
          if (ck_rise) begin
            if (st_ff.cnt == dlen) begin
              // word drained: move on, no dummy bit before later words
              nxt_st.idx = idx_inc;
              nxt_st.so  = word_n[15];
              nxt_st.rsh = {word_n[14:0], 1'b0};
              nxt_st.cnt = 5'h01;
            end else begin
              nxt_st.so  = st_ff.rsh[15];
              nxt_st.rsh = {st_ff.rsh[14:0], 1'b0};
              nxt_st.cnt = st_ff.cnt + 5'h01;
            end
          end
        end
        SEP_ST_DONE: begin
          // extra clocks are don't-care until select drops
        end
        default: nxt_st.state = SEP_ST_IDLE;
      endcase

      // status shows only once a programming cycle has been launched
      if (st_ff.stat && st_ff.state == SEP_ST_IDLE) begin
        nxt_st.oe = 1'b1;
        nxt_st.so = ~st_ff.busy;
      end
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= SEP_REGS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // array update at the end of the timed cycle; no reset, contents persist
  // one wide write in the last timed clock keeps the array single ported;
  // the cost is a full-array write path, acceptable at these depths
  always_ff @(posedge clk_sys_i) begin
    if (prog_done) begin
      for (int i = 0; i < SEP_MEM_BYTES; i++) begin
        unique case (st_ff.kind)
          SEP_OP_READ: mem_ff[i] <= SEP_ERASED[7:0];
          // write all overwrites every byte, so the erase is implied
          SEP_OP_SPECIAL: mem_ff[i] <= (st_ff.wide && i[0]) ? st_ff.dat[15:8]
                                                            : st_ff.dat[7:0];
          SEP_OP_ERASE,
          SEP_OP_WRITE: begin
            if (st_ff.wide && (i[8:1] == st_ff.idx[7:0])) begin
              mem_ff[i] <= i[0] ? ((st_ff.kind == SEP_OP_ERASE) ? SEP_ERASED[15:8]
                                                                 : st_ff.dat[15:8])
                                 : ((st_ff.kind == SEP_OP_ERASE) ? SEP_ERASED[7:0]
                                                                 : st_ff.dat[7:0]);
            end else if (!st_ff.wide && (9'(i) == st_ff.idx)) begin
              mem_ff[i] <= (st_ff.kind == SEP_OP_ERASE) ? SEP_ERASED[7:0] : st_ff.dat[7:0];
            end
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // the data and enable outputs come straight from flops, so the pin never glitches when
  // select falls in the middle of a shifted bit
  assign serial_out_o    = st_ff.so;
  assign serial_out_oe_o = st_ff.oe;
  assign standby_o       = ~st_ff.cs_s & ~st_ff.busy;

endmodule : sep_eeprom

`default_nettype wire

//--- test/sep_eeprom_checker.sv
// pin-level assertions for the serial eeprom device core
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_checker #(
  parameter int unsigned WRITE_ALL_CYC = 200
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic cs_i,
  input wire logic sclk_i,
  input wire logic serial_in_i,
  input wire logic width_select_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  input wire logic standby_o
);
  // ------------------------------------------------
  // select and output rules
  // ------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic [31:0] low_cnt_ff;
  // deselected cycles; saturates so a long idle never wraps back
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) low_cnt_ff <= '0;
    else if (cs_i) low_cnt_ff <= '0;
    else if (low_cnt_ff != 32'hffffffff) low_cnt_ff <= low_cnt_ff + 32'h1;
  end
  sequence s_sel_held;
    cs_i [*5];
  endsequence
  sequence s_desel_held;
    !cs_i [*5];
  endsequence
  a_desel_float: assert property (s_desel_held |-> !serial_out_oe_o)
    else $error("output driven while deselected");
  a_cs_fall_float: assert property ($fell(cs_i) |-> ##[1:5] !serial_out_oe_o)
    else $error("output not released after select fell");
  a_sel_wakes: assert property (s_sel_held |-> !standby_o)
    else $error("standby while selected");
  a_standby_float: assert property (standby_o |=> !serial_out_oe_o)
    else $error("output driven in standby");
  a_drive_needs_sel: assert property ($rose(serial_out_oe_o) |-> $past(cs_i, 2))
    else $error("output enabled without select");
  a_sel_holds_out: assert property (s_sel_held |-> !$fell(serial_out_oe_o))
    else $error("output dropped while selected");
  a_read_dummy: assert property ($rose(serial_out_oe_o) && $past(cs_i, 8) |-> !serial_out_o)
    else $error("read did not start with a zero");
  a_prog_bounded: assert property (low_cnt_ff == 32'(WRITE_ALL_CYC + 16) |-> standby_o)
    else $error("programming outlasted its time");
endmodule : sep_eeprom_checker
`default_nettype wire

//--- test/sep_master.sv
// behavioural serial bus master for the three-wire pins
`timescale 1ns/1ps
`default_nettype none
module sep_master (
  input  wire logic clk_sys_i,
  input  wire logic serial_out_i,
  input  wire logic serial_out_oe_i,
  output logic      cs_o,
  output logic      sclk_o,
  output logic      serial_in_o
);
  // ------------------------------------------------
  // pin model and frame tasks
  // ------------------------------------------------
  logic last_ff;
  logic pin;
  // a floating pin shows the inverse of its last level, never a friendly default
  always_ff @(posedge clk_sys_i) if (serial_out_oe_i) last_ff <= serial_out_i;
  assign pin = serial_out_oe_i ? serial_out_i : ~last_ff;
  initial begin
    cs_o = 1'b0;
    sclk_o = 1'b0;
    serial_in_o = 1'b0;
  end
  // n bits msb first; clock stands low outside frames; pin sampled before each rise
  task automatic frame(input logic [63:0] v, input int n, output logic [63:0] rd);
    rd = '0;
    // eighth-clock offset: 62.5 ns steps from here never land on a system edge
    #1.25;
    cs_o = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      serial_in_o = v[i];
      #62.5;
      rd = {rd[62:0], pin};
      sclk_o = 1'b1;
      #62.5;
    end
    rd = {rd[62:0], pin};
    sclk_o = 1'b0;
    serial_in_o = ~serial_in_o;
  endtask : frame
  // deselect before any further rise, then hold low past the minimum low time
  task automatic cs_drop();
    cs_o = 1'b0;
    #300;
  endtask : cs_drop
endmodule : sep_master
`default_nettype wire

//--- test/tb_three_wire_serial_eeprom_interface.sv
// self-checking bench for the serial eeprom device core
`timescale 1ns/1ps
`default_nettype none
module tb_three_wire_serial_eeprom_interface;
  import sep_pkg::*;
  // ------------------------------------------------
  // setup; short timers keep the run brief
  // ------------------------------------------------
  localparam int unsigned WP = 50;
  localparam int unsigned EA = 100;
  localparam int unsigned WA = 200;
  logic        clk_sys_i;
  logic        resetn_i;
  logic        wsel;
  wire logic   cs_w;
  wire logic   sclk_w;
  wire logic   sdi_w;
  wire logic   sdo_w;
  wire logic   soe_w;
  wire logic   stby_w;
  int          err_count;
  int          checked;
  integer      seed;
  int          mem [0:127];
  logic [63:0] rd;
  sep_eeprom #(.PART_SEL(SEP_PART_1K), .WORD_PROG_CYC(WP), .ERASE_ALL_CYC(EA),
    .WRITE_ALL_CYC(WA)) uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cs_i(cs_w),
    .sclk_i(sclk_w), .serial_in_i(sdi_w), .width_select_i(wsel), .serial_out_o(sdo_w),
    .serial_out_oe_o(soe_w), .standby_o(stby_w));
  sep_master u_master (.clk_sys_i(clk_sys_i), .serial_out_i(sdo_w),
    .serial_out_oe_i(soe_w), .cs_o(cs_w), .sclk_o(sclk_w), .serial_in_o(sdi_w));
  task automatic end_sim();
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [32:0] e, input logic [32:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : check
  // x16 words pair bytes low then high; the address wraps past the top
  function automatic logic [15:0] w16(input int a);
    return {mem[(2 * a + 1) % 128][7:0], mem[(2 * a) % 128][7:0]};
  endfunction : w16
  // two idle zeros ahead of the start bit, then opcode, address and dl data bits
  task automatic op(input int opc, input int adr, input int dat, input int dl);
    int          ab;
    logic [63:0] v;
    ab = wsel ? 6 : 7;
    v = (64'h4 | 64'(opc)) << ab | 64'(adr % (1 << ab));
    v = (v << dl) | 64'(dat);
    @(negedge clk_sys_i);
    u_master.frame(v, 5 + ab + dl, rd);
    u_master.cs_drop();
  endtask : op
  // reselect; a refused command leaves the pin floating
  task automatic status(input logic busy, input int lim);
    int k;
    u_master.cs_o = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    check("status_oe", 33'(busy), 33'(soe_w));
    if (busy) begin
      check("busy_level", 33'h0, 33'(sdo_w));
      k = 0;
      while (sdo_w !== 1'b1 && k < lim + 40) begin
        @(negedge clk_sys_i);
        k++;
      end
      if (k >= lim + 40) begin
        $display("BAD ready exp 1 got %b", sdo_w);
        err_count++;
        end_sim();
      end
    end
    u_master.cs_drop();
  endtask : status
  task automatic rdchk(input int a);
    logic [32:0] e;
    e = wsel ? {1'b0, w16(a), w16(a + 1)} :
      {17'h0, mem[a % 128][7:0], mem[(a + 1) % 128][7:0]};
    op(2, a, 0, wsel ? 32 : 16);
    check("read", e, wsel ? rd[32:0] : {16'h0, rd[16:0]});
  endtask : rdchk
  // ------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #800us;
    $display("BAD watchdog exp done got hang");
    err_count++;
    end_sim();
  end
  initial begin
    int a;
    int d;
    err_count = 0;
    checked = 0;
    seed = 32'h9fd1081c;
    resetn_i = 1'b0;
    wsel = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check("standby", 33'h1, 33'(stby_w));
    u_master.frame(64'h0, 12, rd);
    check("idle_oe", 33'h0, 33'(soe_w));
    u_master.cs_drop();
    op(1, 4, 16'h1234, 16);
    status(1'b0, 0);
    op(0, 6'h30, 0, 0);
    status(1'b0, 0);
    for (int i = 0; i < 3; i++) begin
      a = (i == 2) ? 63 : 4 + i;
      d = $random(seed) & 16'hffff;
      op(1, a, d, 16);
      status(1'b1, WP);
      mem[2 * a] = d & 255;
      mem[2 * a + 1] = d >> 8;
    end
    op(3, 0, 0, 0);
    status(1'b1, WP);
    mem[0] = 255;
    mem[1] = 255;
    rdchk(63);
    rdchk(4);
    d = $random(seed) & 16'hffff;
    op(0, 6'h10, d, 16);
    status(1'b1, WA);
    for (int i = 0; i < 128; i++) mem[i] = (i % 2) ? d >> 8 : d & 255;
    rdchk(20);
    op(0, 6'h20, 0, 0);
    status(1'b1, EA);
    for (int i = 0; i < 128; i++) mem[i] = 255;
    rdchk(62);
    wsel = 1'b0;
    d = $random(seed) & 8'hff;
    op(1, 85, d, 8);
    status(1'b1, WP);
    mem[85] = d;
    rdchk(85);
    op(0, 7'h00, 0, 0);
    status(1'b0, 0);
    op(1, 85, d ^ 255, 8);
    status(1'b0, 0);
    rdchk(85);
    repeat (250) @(negedge clk_sys_i);
    end_sim();
  end
endmodule : tb_three_wire_serial_eeprom_interface
bind sep_eeprom sep_eeprom_checker #(.WRITE_ALL_CYC(WRITE_ALL_CYC)) u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cs_i(cs_i), .sclk_i(sclk_i),
  .serial_in_i(serial_in_i), .width_select_i(width_select_i),
  .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o), .standby_o(standby_o));
`default_nettype wire
